// File: scm_clk_consumer.sv
// Clock consumer model: counts rising edges of the system clock.
// Assumes sys_clk is a level made on clk.
`timescale 1ns/100ps
`default_nettype none
module scm_clk_consumer (
  input  wire logic        clk,     // Bench clock
  input  wire logic        reset_n, // Reset, active low
  input  wire logic        sys_clk, // Consumed clock
  output logic      [15:0] rises    // Rising edges seen
);
  logic prev_reg; // Last sys_clk
  // A stopped branch simply stops the count
  always_ff @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      prev_reg <= 1'b0;
      rises    <= 16'h0000;
    end
    else
    begin
      prev_reg <= sys_clk;
      rises    <= rises + 16'(sys_clk & !prev_reg);
    end
endmodule
`default_nettype wire

// File: scm_pkg.sv
// Shared constants, register map and carrier types of the system clock and mode controller.
// Assumes a single 50 MHz system clock; the oscillators are modelled as tick strobes on it.
// ****************************************
// Timing and register constants
// ****************************************
package scm_pkg;
  localparam int CLK_PERIOD_NS = 20;                       // System clock period
  localparam int CLK_KHZ       = 1000000 / CLK_PERIOD_NS;  // System clock rate
  localparam int FAST_OSC_KHZ  = 8000;                     // Fast RC oscillator, fixed
  localparam int SLOW_OSC_KHZ  = 32;                       // Slow RC oscillator, nominal
  localparam int ACC_W         = 20;                       // Tick accumulator width
  localparam int CNT_W         = 16;                       // Start-up counter width
  // Oscillator start-up times, least times rounded up to whole cycles
  localparam int HS_START_NS   = 2000;
  localparam int HS_START_CYC  = (HS_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LS_START_NS   = 200000;
  localparam int LS_START_CYC  = (LS_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [3:0] OFS_CLK_CTRL  = 4'h0;
  localparam logic [3:0] OFS_HS_CTRL   = 4'h4;
  localparam logic [3:0] OFS_MODE_STAT = 4'h8;
  // Field positions
  localparam int SEL_LSB       = 5;
  localparam int HS_KEEP_BIT   = 1;
  localparam int LS_KEEP_BIT   = 0;
  localparam int HS_STABLE_BIT = 1;
  localparam int HS_EN_BIT     = 0;
  localparam int ACT_SEL_LSB   = 8;
  localparam int LS_STABLE_BIT = 11;
  // Values after reset and encodings
  localparam logic [2:0]  SEL_RST    = 3'h0;
  localparam logic [2:0]  SEL_SLOW   = 3'h7;
  localparam logic        HS_EN_RST  = 1'b1;
  localparam logic        KEEP_RST   = 1'b0;
  localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [5:0] {
    MODE_FAST                = 6'h01,
    MODE_SLOW                = 6'h02,
    MODE_SLEEP               = 6'h04,
    MODE_IDLE_LOWSPEED_ONLY  = 6'h08,
    MODE_IDLE_BOTH_OSC       = 6'h10,
    MODE_IDLE_HIGHSPEED_ONLY = 6'h20
  } scm_mode_t;

  typedef struct packed {
    logic cpu_run;  // CPU clock branch running
    logic sys_run;  // System clock branch running
    logic hs_run;   // Fast oscillator and high speed clock running
    logic ls_run;   // Low speed clock to peripherals running
    logic raw_run;  // Raw slow oscillator clock running
  } scm_clk_run_t;
endpackage

// File: scm_sysclk_mode_ctrl.sv
// System clock selection and operating mode control with an Avalon-MM register slave.
// Assumes halt, wake and watchdog-enable come from logic on the same clock.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module scm_sysclk_mode_ctrl #(
  parameter int LS_START_CYCLES = scm_pkg::LS_START_CYC  // Slow oscillator start-up cycles
) (
  input  wire logic                  clk,             // System clock, 50 MHz
  input  wire logic                  reset_n,         // Asynchronous reset, active low
  input  wire logic [3:0]            avs_address,     // Byte address
  input  wire logic                  avs_read,        // Read request
  input  wire logic                  avs_write,       // Write request
  input  wire logic [31:0]           avs_writedata,   // Write data
  input  wire logic [3:0]            avs_byteenable,  // Byte enables
  output logic [31:0]                avs_readdata,    // Read data
  output logic                       avs_waitrequest, // Stall
  input  wire logic                  halt_req,        // Halt instruction strobe
  input  wire logic                  wake_req,        // Wake-up strobe
  input  wire logic                  wdt_enable,      // Watchdog function enabled
  output scm_pkg::scm_clk_run_t      clk_run,         // Branch run levels
  output logic                       sys_clk,         // Generated system clock
  output logic                       high_speed_clk,  // High speed tick strobe
  output logic [5:0]                 hs_div_tick,     // Ticks of fast clock /2 to /64
  output logic                       low_speed_clk    // Low speed tick strobe
);
  // ****************************************
  // Declarations
  // ****************************************
  scm_pkg::scm_mode_t     mode_reg;
  logic [2:0]             sys_clk_select;
  logic                   hs_osc_idle_keep;
  logic                   ls_osc_idle_keep;
  logic                   hs_osc_enable;
  logic [2:0]             act_sel_reg;
  logic                   sys_clk_reg;
  logic [5:0]             div_cnt_reg;
  logic [scm_pkg::CNT_W-1:0] hs_cnt_reg;
  logic [scm_pkg::CNT_W-1:0] ls_cnt_reg;
  logic                   ack_reg;
  logic [31:0]            rdata_reg;
  logic                   wr_fire;
  logic                   hs_restart;
  logic                   hs_on;
  logic                   raw_on;
  logic                   hs_tick;
  logic                   ls_tick;
  logic                   hs_osc_stable_flag;
  logic                   ls_stable;
  logic                   cur_tick;
  logic                   target_ready;
  logic                   do_switch;
  logic                   is_run;
  logic [31:0]            rd_mux;

  // Tick of the fast clock divided by two to the power sel
  function automatic logic div_tick(input logic [2:0] sel, input logic [5:0] cnt,
                                    input logic t);
    logic [5:0] mask;
    mask = 6'h3F >> (3'h6 - sel);
    return t && ((cnt & mask) == mask);
  endfunction

  // ****************************************
  // Register slave
  // ****************************************
  // One wait state per access keeps read data registered
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign wr_fire         = avs_write && ack_reg && avs_byteenable[0];
  assign avs_readdata    = rdata_reg;
  assign hs_restart      = wr_fire && (avs_address == scm_pkg::OFS_HS_CTRL)
                           && avs_writedata[scm_pkg::HS_EN_BIT] && !hs_osc_enable;

  // Acknowledge strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read || avs_write) && !ack_reg;
  end

  // Read decode; unmapped offsets read as zero
  always_comb
  begin
    rd_mux = scm_pkg::DATA_ZERO;
    if (avs_address == scm_pkg::OFS_CLK_CTRL)
    begin
      rd_mux[scm_pkg::SEL_LSB +: 3]      = sys_clk_select;
      rd_mux[scm_pkg::HS_KEEP_BIT]       = hs_osc_idle_keep;
      rd_mux[scm_pkg::LS_KEEP_BIT]       = ls_osc_idle_keep;
    end
    else if (avs_address == scm_pkg::OFS_HS_CTRL)
    begin
      rd_mux[scm_pkg::HS_STABLE_BIT]     = hs_osc_stable_flag;
      rd_mux[scm_pkg::HS_EN_BIT]         = hs_osc_enable;
    end
    else if (avs_address == scm_pkg::OFS_MODE_STAT)
    begin
      rd_mux[5:0]                        = mode_reg;
      rd_mux[scm_pkg::ACT_SEL_LSB +: 3]  = act_sel_reg;
      rd_mux[scm_pkg::LS_STABLE_BIT]     = ls_stable;
    end
  end

  // Read data captured in the stall cycle, valid while waitrequest is low
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_reg <= scm_pkg::DATA_ZERO;
    else if (avs_read && !ack_reg)
      rdata_reg <= rd_mux;
  end

  // Clock control register; writes to other offsets are ignored
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sys_clk_select   <= scm_pkg::SEL_RST;
      hs_osc_idle_keep <= scm_pkg::KEEP_RST;
      ls_osc_idle_keep <= scm_pkg::KEEP_RST;
    end
    else if (wr_fire && (avs_address == scm_pkg::OFS_CLK_CTRL))
    begin
      sys_clk_select   <= avs_writedata[scm_pkg::SEL_LSB +: 3];
      hs_osc_idle_keep <= avs_writedata[scm_pkg::HS_KEEP_BIT];
      ls_osc_idle_keep <= avs_writedata[scm_pkg::LS_KEEP_BIT];
    end
  end

  // Fast oscillator enable; the stable flag is read-only
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hs_osc_enable <= scm_pkg::HS_EN_RST;
    else if (wr_fire && (avs_address == scm_pkg::OFS_HS_CTRL))
      hs_osc_enable <= avs_writedata[scm_pkg::HS_EN_BIT];
  end

  // ****************************************
  // Oscillators
  // ****************************************
  // Fast oscillator runs in fast mode and in the idle modes that keep it; in slow mode only if enabled or a fast source is selected
  always_comb
  begin
    hs_on = 1'b0;
    case (mode_reg)
      scm_pkg::MODE_FAST:                hs_on = 1'b1;
      scm_pkg::MODE_SLOW:                hs_on = hs_osc_enable
                                                 || (sys_clk_select != scm_pkg::SEL_SLOW);
      scm_pkg::MODE_IDLE_BOTH_OSC:       hs_on = 1'b1;
      scm_pkg::MODE_IDLE_HIGHSPEED_ONLY: hs_on = 1'b1;
      default:                           hs_on = 1'b0;
    endcase
  end

  // Raw slow clock stops only in sleep without the watchdog
  assign raw_on = !((mode_reg == scm_pkg::MODE_SLEEP) && !wdt_enable);

  // Oscillator models at their nominal rates
  scm_tick_gen #(
    .INC   (scm_pkg::FAST_OSC_KHZ),
    .MOD   (scm_pkg::CLK_KHZ),
    .ACC_W (scm_pkg::ACC_W)
  ) u_fast_rc_osc (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (hs_on),
    .tick    (hs_tick)
  );

  scm_tick_gen #(
    .INC   (scm_pkg::SLOW_OSC_KHZ),
    .MOD   (scm_pkg::CLK_KHZ),
    .ACC_W (scm_pkg::ACC_W)
  ) u_slow_rc_osc (
    .clk     (clk),
    .reset_n (reset_n),
    .run     (raw_on),
    .tick    (ls_tick)
  );

  // Fast start-up counter; enabling from off restarts it so the flag reads 0 first
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hs_cnt_reg <= '0;
    else if (!hs_on || hs_restart)
      hs_cnt_reg <= '0;
    else if (hs_cnt_reg != scm_pkg::CNT_W'(scm_pkg::HS_START_CYC))
      hs_cnt_reg <= hs_cnt_reg + 1'b1;
  end

  // Slow start-up counter
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ls_cnt_reg <= '0;
    else if (!raw_on)
      ls_cnt_reg <= '0;
    else if (ls_cnt_reg != scm_pkg::CNT_W'(LS_START_CYCLES))
      ls_cnt_reg <= ls_cnt_reg + 1'b1;
  end

  assign hs_osc_stable_flag = (hs_cnt_reg == scm_pkg::CNT_W'(scm_pkg::HS_START_CYC));
  assign ls_stable          = (ls_cnt_reg == scm_pkg::CNT_W'(LS_START_CYCLES));

  // ****************************************
  // Clock branches
  // ****************************************
  // Divider of the fast clock shared by the system mux and peripherals
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      div_cnt_reg <= 6'h00;
    else if (hs_tick)
      div_cnt_reg <= div_cnt_reg + 6'h01;
  end

  generate
    for (genvar k = 0; k < 6; k++)
    begin : g_div
      assign hs_div_tick[k] = div_tick(3'(k + 1), div_cnt_reg, hs_tick);
    end
  endgenerate

  assign high_speed_clk = hs_tick;
  assign low_speed_clk  = ls_tick && clk_run.ls_run;

  // Branch run levels decoded from the mode
  assign clk_run.cpu_run = (mode_reg == scm_pkg::MODE_FAST)
                           || (mode_reg == scm_pkg::MODE_SLOW);
  assign clk_run.hs_run  = hs_on;
  assign clk_run.raw_run = raw_on;
  assign clk_run.ls_run  = (mode_reg == scm_pkg::MODE_FAST) || (mode_reg == scm_pkg::MODE_SLOW)
                           || (mode_reg == scm_pkg::MODE_IDLE_LOWSPEED_ONLY)
                           || (mode_reg == scm_pkg::MODE_IDLE_BOTH_OSC);
  assign clk_run.sys_run = clk_run.cpu_run || (mode_reg == scm_pkg::MODE_IDLE_BOTH_OSC)
                           || ((mode_reg == scm_pkg::MODE_IDLE_LOWSPEED_ONLY)
                               && (act_sel_reg == scm_pkg::SEL_SLOW))
                           || ((mode_reg == scm_pkg::MODE_IDLE_HIGHSPEED_ONLY)
                               && (act_sel_reg != scm_pkg::SEL_SLOW));

  // Tick of the active source: slow clock or divided fast clock
  assign cur_tick = (act_sel_reg == scm_pkg::SEL_SLOW) ? ls_tick
                    : div_tick(act_sel_reg, div_cnt_reg, hs_tick);

  // Change over only while the output is low, so no phase is cut short
  assign target_ready = (sys_clk_select == scm_pkg::SEL_SLOW) ? ls_stable
                        : hs_osc_stable_flag;
  assign do_switch    = (sys_clk_select != act_sel_reg) && target_ready && !sys_clk_reg
                        && (cur_tick || !clk_run.sys_run);

  // Active selection follows the requested one at a safe point
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      act_sel_reg <= scm_pkg::SEL_RST;
    else if (do_switch)
      act_sel_reg <= sys_clk_select;
  end

  // System clock output; a stopped branch parks low after finishing its high phase if its source still ticks, else holds its level
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sys_clk_reg <= 1'b0;
    else if (!do_switch && cur_tick && (clk_run.sys_run || sys_clk_reg))
      sys_clk_reg <= !sys_clk_reg;
  end

  assign sys_clk = sys_clk_reg;

  // ****************************************
  // Operating mode machine
  // ****************************************
  assign is_run = (mode_reg == scm_pkg::MODE_FAST) || (mode_reg == scm_pkg::MODE_SLOW);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      mode_reg <= scm_pkg::MODE_FAST;
    else
    begin
      case (mode_reg)
        scm_pkg::MODE_FAST, scm_pkg::MODE_SLOW:
        begin
          if (halt_req)
          begin
            case ({hs_osc_idle_keep, ls_osc_idle_keep})
              2'b00:   mode_reg <= scm_pkg::MODE_SLEEP;
              2'b01:   mode_reg <= scm_pkg::MODE_IDLE_LOWSPEED_ONLY;
              2'b11:   mode_reg <= scm_pkg::MODE_IDLE_BOTH_OSC;
              default: mode_reg <= scm_pkg::MODE_IDLE_HIGHSPEED_ONLY;
            endcase
          end
          else if (act_sel_reg == scm_pkg::SEL_SLOW)
            mode_reg <= scm_pkg::MODE_SLOW;
          else
            mode_reg <= scm_pkg::MODE_FAST;
        end
        default:
        begin
          if (wake_req)
            mode_reg <= (act_sel_reg == scm_pkg::SEL_SLOW) ? scm_pkg::MODE_SLOW
                                                           : scm_pkg::MODE_FAST;
        end
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_halt_sleep;
    @(posedge clk) disable iff (!reset_n)
    (is_run && halt_req && !hs_osc_idle_keep && !ls_osc_idle_keep)
      |=> (mode_reg == scm_pkg::MODE_SLEEP) && !clk_run.hs_run && !clk_run.ls_run
          && !clk_run.sys_run && !clk_run.cpu_run;
  endproperty
  a_halt_sleep: assert property (p_halt_sleep) else $error("sleep entry wrong");

  property p_sleep_raw;
    @(posedge clk) disable iff (!reset_n)
    (mode_reg == scm_pkg::MODE_SLEEP) |-> (clk_run.raw_run == wdt_enable);
  endproperty
  a_sleep_raw: assert property (p_sleep_raw) else $error("raw slow clock wrong");

  property p_halt_idle_ls;
    @(posedge clk) disable iff (!reset_n)
    (is_run && halt_req && !hs_osc_idle_keep && ls_osc_idle_keep)
      |=> clk_run.ls_run && !clk_run.hs_run && !clk_run.cpu_run;
  endproperty
  a_halt_idle_ls: assert property (p_halt_idle_ls) else $error("idle ls entry wrong");

  property p_idle_ls_sys;
    @(posedge clk) disable iff (!reset_n)
    (mode_reg == scm_pkg::MODE_IDLE_LOWSPEED_ONLY)
      |-> (clk_run.sys_run == (act_sel_reg == scm_pkg::SEL_SLOW));
  endproperty
  a_idle_ls_sys: assert property (p_idle_ls_sys) else $error("idle ls branch wrong");

  property p_halt_idle_both;
    @(posedge clk) disable iff (!reset_n)
    (is_run && halt_req && hs_osc_idle_keep && ls_osc_idle_keep)
      |=> clk_run.hs_run && clk_run.ls_run && clk_run.sys_run && clk_run.raw_run
          && !clk_run.cpu_run;
  endproperty
  a_halt_idle_both: assert property (p_halt_idle_both) else $error("idle both wrong");

  property p_halt_idle_hs;
    @(posedge clk) disable iff (!reset_n)
    (is_run && halt_req && hs_osc_idle_keep && !ls_osc_idle_keep)
      |=> clk_run.hs_run && !clk_run.ls_run && !clk_run.cpu_run;
  endproperty
  a_halt_idle_hs: assert property (p_halt_idle_hs) else $error("idle hs entry wrong");

  property p_idle_hs_sys;
    @(posedge clk) disable iff (!reset_n)
    (mode_reg == scm_pkg::MODE_IDLE_HIGHSPEED_ONLY)
      |-> (clk_run.sys_run == (act_sel_reg != scm_pkg::SEL_SLOW));
  endproperty
  a_idle_hs_sys: assert property (p_idle_hs_sys) else $error("idle hs branch wrong");

  property p_fast_all_on;
    @(posedge clk) disable iff (!reset_n)
    (mode_reg == scm_pkg::MODE_FAST)
      |-> clk_run.cpu_run && clk_run.hs_run && clk_run.ls_run && clk_run.raw_run;
  endproperty
  a_fast_all_on: assert property (p_fast_all_on) else $error("fast mode clock off");

  property p_slow_hs_off;
    @(posedge clk) disable iff (!reset_n)
    ((mode_reg == scm_pkg::MODE_SLOW) && !hs_osc_enable
      && (sys_clk_select == scm_pkg::SEL_SLOW)) |-> !clk_run.hs_run;
  endproperty
  a_slow_hs_off: assert property (p_slow_hs_off) else $error("fast osc not stopped");

  property p_hs_restart;
    @(posedge clk) disable iff (!reset_n)
    hs_restart |=> !hs_osc_stable_flag ##1 !hs_osc_stable_flag;
  endproperty
  a_hs_restart: assert property (p_hs_restart) else $error("stable flag not cleared");

  property p_slow_switch;
    @(posedge clk) disable iff (!reset_n)
    ($changed(act_sel_reg) && (act_sel_reg == scm_pkg::SEL_SLOW)) |-> $past(ls_stable);
  endproperty
  a_slow_switch: assert property (p_slow_switch) else $error("slow switch too early");

  property p_div64;
    @(posedge clk) disable iff (!reset_n)
    ((act_sel_reg == 3'h6) && $rose(sys_clk_reg)) |-> ($past(div_cnt_reg) == 6'h3F);
  endproperty
  a_div64: assert property (p_div64) else $error("divide by 64 edge wrong");

  property p_no_glitch;
    @(posedge clk) disable iff (!reset_n)
    $changed(act_sel_reg) |-> !sys_clk_reg && !$past(sys_clk_reg);
  endproperty
  a_no_glitch: assert property (p_no_glitch) else $error("switch during high phase");
endmodule
`default_nettype wire

// File: scm_sysclk_mode_ctrl_test.sv
// Bench for the clock and mode controller: registers, halt and wake, divider.
// Assumes the consumer model counts sys_clk rising edges.
`timescale 1ns/100ps
`default_nettype none
module scm_sysclk_mode_ctrl_test;
  localparam logic [3:0] CT = scm_pkg::OFS_CLK_CTRL;
  localparam logic [3:0] HS = scm_pkg::OFS_HS_CTRL;
  localparam logic [3:0] ST = scm_pkg::OFS_MODE_STAT;
  logic clk, reset_n, avs_read, avs_write, halt_req, wake_req, wdt_enable, chk_on, sys_clk;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_val;
  logic avs_waitrequest, high_speed_clk, low_speed_clk;
  logic [5:0] hs_div_tick;
  logic [15:0] rises, r0;
  logic [15:0] hs_n = 16'h0000, dv_n = 16'h0000, ls_n = 16'h0000, h0, d0, l0;
  logic [2:0] dk = 3'h0;
  logic [2:0] sel;
  scm_pkg::scm_clk_run_t clk_run;
  logic [63:0] exp_q[$];
  int errors = 0;
  int checked = 0;
  int n;
  logic [4:0] ex [4] = '{5'h00, 5'h03, 5'h0F, 5'h0D};
  logic [1:0] kp [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  logic [5:0] md [4] = '{6'h04, 6'h08, 6'h10, 6'h20};
  scm_sysclk_mode_ctrl #(.LS_START_CYCLES(4)) dut (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .halt_req(halt_req), .wake_req(wake_req),
    .wdt_enable(wdt_enable), .clk_run(clk_run), .sys_clk(sys_clk),
    .high_speed_clk(high_speed_clk), .hs_div_tick(hs_div_tick), .low_speed_clk(low_speed_clk));
  scm_clk_consumer cons (.clk(clk), .reset_n(reset_n), .sys_clk(sys_clk), .rises(rises));
  // Free-running 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic tally_and_finish;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", s, e, g);
      errors++;
    end
  endtask
  // Read data is matched, under its mask, against the oldest note
  always @(posedge clk)
    if (avs_read && avs_waitrequest === 1'b0 && chk_on)
    begin
      if (exp_q.size() > 0)
      begin
        chk("readdata", exp_q[0][31:0], avs_readdata & exp_q[0][63:32]);
        void'(exp_q.pop_front());
      end
      else
        chk("readdata_note", 32'h0000_0001, 32'h0000_0000);
    end
  // Peripheral strobe counts, so the branch outputs are measured like sys_clk
  always @(posedge clk)
  begin
    hs_n <= hs_n + 16'(high_speed_clk);
    dv_n <= dv_n + 16'(hs_div_tick[dk]);
    ls_n <= ls_n + 16'(low_speed_clk);
  end
  // One bus cycle; the request holds until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic ck, input logic [63:0] e);
    int k;
    @(posedge clk);
    if (ck)
      exp_q.push_back(e);
    chk_on <= ck;
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 50);
    rd_val = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (k >= 50)
    begin
      errors++;
      tally_and_finish;
    end
  endtask
  // Mode switches take oscillator start-up time, so poll with a bound
  task automatic poll(input logic [5:0] m);
    n = 0;
    do
    begin
      bus(0, ST, 0, 0, 0);
      n++;
    end
    while (rd_val[5:0] !== m && n < 5000);
    chk("mode", 32'(m), 32'(rd_val[5:0]));
    if (n >= 5000)
      tally_and_finish;
  endtask
  // Halt or wake strobe, then the branch levels one edge later
  task automatic pulse(input logic h, input logic [4:0] e);
    @(posedge clk);
    halt_req <= h;
    wake_req <= !h;
    @(posedge clk);
    halt_req <= 1'b0;
    wake_req <= 1'b0;
    @(posedge clk);
    #1;
    chk("clk_run", 32'(e), 32'(clk_run));
  endtask
  // Main sequence
  initial
  begin
    {reset_n, avs_read, avs_write, halt_req, wake_req, chk_on, wdt_enable} = 7'h00;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    void'($urandom(32'hc9ff_6e32));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    bus(0, CT, 0, 1, {32'hFFFF_FFFF, 32'h0000_0000});
    bus(0, 4'hC, 0, 1, {32'hFFFF_FFFF, 32'h0000_0000});
    repeat (120) @(posedge clk);
    bus(0, HS, 0, 1, {32'hFFFF_FFFF, 32'h0000_0003});
    chk("clk_run", 32'h0000_001F, 32'(clk_run));
    // Each fast code 0 to 6 must give the fast tick rate halved code plus one times, within one edge
    for (int s = 0; s < 7; s++)
    begin
      bus(1, CT, 32'(s) << 5, 0, 0);
      dk = 3'(s % 6);
      repeat (1000) @(posedge clk);
      r0 = rises;
      h0 = hs_n;
      d0 = dv_n;
      l0 = ls_n;
      repeat (3200) @(posedge clk);
      chk("rises", 1, 32'((int'(rises - r0) - (256 >> s) + 1) inside {[0:2]}));
      chk("high_speed_clk", 32'h0000_0200, 32'(hs_n - h0));
      chk("hs_div_tick", 1, 32'((int'(dv_n - d0) - (256 >> dk) + 1) inside {[0:2]}));
      chk("low_speed_clk", 1, 32'((ls_n - l0) inside {[1:3]}));
    end
    for (int i = 0; i < 4; i++)
    begin
      sel = 3'($urandom_range(6));
      @(posedge clk);
      wdt_enable <= 1'($urandom);
      bus(1, CT, {24'h0, sel, 3'h0, kp[i]}, 0, 0);
      pulse(1, ex[i] | {4'h0, i == 0 && wdt_enable});
      bus(0, ST, 0, 1, {32'h3F, 26'h0, md[i]});
      pulse(0, 5'h1F);
    end
    bus(1, CT, {24'h0, 3'h7, 5'h0}, 0, 0);
    poll(6'h02);
    bus(0, ST, 0, 1, {32'hFFF, 32'hF02});
    bus(1, CT, {24'h0, 3'h7, 5'h1}, 0, 0);
    pulse(1, 5'h0B);
    pulse(0, 5'h1F);
    bus(1, CT, {24'h0, 3'h7, 5'h2}, 0, 0);
    pulse(1, 5'h05);
    pulse(0, 5'h1F);
    bus(1, HS, 0, 0, 0);
    #1;
    chk("clk_run", 32'h0000_001B, 32'(clk_run));
    bus(0, HS, 0, 1, {32'hFFFF_FFFF, 32'h0000_0000});
    bus(1, HS, 1, 0, 0);
    bus(0, HS, 0, 1, {32'hFFFF_FFFF, 32'h0000_0001});
    sel = 3'($urandom_range(6));
    bus(1, CT, {24'h0, sel, 5'h0}, 0, 0);
    poll(6'h01);
    bus(0, ST, 0, 1, {32'h7FF, 21'h0, sel, 8'h01});
    tally_and_finish;
  end
endmodule
`default_nettype wire

// File: scm_tick_gen.sv
// Fractional tick generator that stands in for an RC oscillator.
// Assumes the system clock is faster than the modelled oscillator (INC below MOD).
`timescale 1ns/100ps
`default_nettype none
module scm_tick_gen #(
  parameter int INC   = 1,   // Oscillator rate
  parameter int MOD   = 2,   // System clock rate, same unit
  parameter int ACC_W = 20   // Accumulator width
) (
  input  wire logic clk,     // System clock
  input  wire logic reset_n, // Asynchronous reset, active low
  input  wire logic run,     // Oscillator enabled
  output logic      tick     // One-cycle strobe per oscillator period
);
  localparam logic [ACC_W-1:0] INC_V = ACC_W'(INC);
  localparam logic [ACC_W-1:0] MOD_V = ACC_W'(MOD);

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W:0]   sum;

  // Phase sum; one bit wider so the wrap is never lost
  assign sum = {1'b0, acc_reg} + {1'b0, INC_V};

  // Accumulate phase; a stopped oscillator restarts from zero phase
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_reg <= '0;
      tick    <= 1'b0;
    end
    else if (!run)
    begin
      acc_reg <= '0;
      tick    <= 1'b0;
    end
    else if (sum >= {1'b0, MOD_V})
    begin
      acc_reg <= ACC_W'(sum - {1'b0, MOD_V});
      tick    <= 1'b1;
    end
    else
    begin
      acc_reg <= sum[ACC_W-1:0];
      tick    <= 1'b0;
    end
  end
endmodule
`default_nettype wire
